//--- hdl/lcrp_lane.sv
// lcrp_lane: effective controls and multifunction pin of one lane.
// assumes register value, global word and status come from logic on the same clock.
`timescale 1ns/100ps
module lcrp_lane #(
	parameter int unsigned LOSS_BIT = 1,
	parameter int unsigned PASS_BIT = 5
) (
	input  wire logic              clk_i,       // system clock
	input  wire logic              rst_i,       // async reset, high
	input  wire logic [15:0]       lane_reg_i,  // lane register value
	input  wire logic [15:0]       global_i,    // global configuration word
	input  wire logic [15:0]       base_i,      // base control word
	input  wire logic [15:0]       status_i,    // lane status word
	input  wire logic              comma_i,     // comma seen on this lane
	input  wire logic              hstl_i,      // io standard, synchronised
	input  wire logic              align_i,     // align enable pin, synchronised
	output lcrp_pkg::lcrp_eff_s    eff_o        // registered effective controls
);

	lcrp_pkg::lcrp_eff_s eff_q;
	lcrp_pkg::lcrp_eff_s eff_d;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		eff_d          = eff_q;
		eff_d.ctc_en   = lane_reg_i[lcrp_pkg::F_CTC] | global_i[lcrp_pkg::F_CTC];
		eff_d.mf_sel   = lane_reg_i[lcrp_pkg::F_MF_HI:lcrp_pkg::F_MF_LO]
			| global_i[lcrp_pkg::F_MF_HI:lcrp_pkg::F_MF_LO];
		eff_d.loss_en  = lane_reg_i[lcrp_pkg::F_LOS_EN] & global_i[lcrp_pkg::F_LOS_EN];
		eff_d.cfg      = lane_reg_i[lcrp_pkg::F_CFG_UP:lcrp_pkg::F_CFG_LO]
			| global_i[lcrp_pkg::F_CFG_UP:lcrp_pkg::F_CFG_LO];
		eff_d.emph     = lane_reg_i[lcrp_pkg::F_EMPH_HI:lcrp_pkg::F_EMPH_LO]
			| global_i[lcrp_pkg::F_EMPH_HI:lcrp_pkg::F_EMPH_LO];
		eff_d.loop_en  = lane_reg_i[lcrp_pkg::F_LOOP] | base_i[lcrp_pkg::BASE_LOOP];
		eff_d.pat_en   = lane_reg_i[lcrp_pkg::F_PAT] | global_i[lcrp_pkg::F_PAT];
		eff_d.comma_en = lane_reg_i[lcrp_pkg::F_COMMA] & align_i
			& global_i[lcrp_pkg::F_COMMA];
		eff_d.pwr_down = lane_reg_i[lcrp_pkg::F_PD] | base_i[lcrp_pkg::BASE_PD];
		// the pin follows the select of this same cycle, not the registered one
		unique case (eff_d.mf_sel)
			lcrp_pkg::MF_IO_STD: eff_d.multi_pin = hstl_i;
			lcrp_pkg::MF_COMMA:  eff_d.multi_pin = comma_i;
			lcrp_pkg::MF_LOSS:   eff_d.multi_pin = status_i[LOSS_BIT];
			lcrp_pkg::MF_PASS:   eff_d.multi_pin = status_i[PASS_BIT];
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			eff_q <= '0;
		end else begin
			eff_q <= eff_d;
		end
	end

	assign eff_o = eff_q;

endmodule : lcrp_lane

//--- hdl/lcrp_pkg.sv
// lcrp_pkg: constants and carrier types for the lane configuration register pair.
// assumes an apb slave on a single 250 MHz clock with asynchronous active-high reset.
package lcrp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register map: the printed offsets are register indices, byte address is four times
	localparam logic [7:0]  LANE_B_IDX      = 8'h12;
	localparam logic [7:0]  LANE_C_IDX      = 8'h13;
	localparam logic [9:0]  LANE_B_ADDR     = {LANE_B_IDX, 2'b00};
	localparam logic [9:0]  LANE_C_ADDR     = {LANE_C_IDX, 2'b00};
	localparam int unsigned ADDR_W          = 10;

	////////////////////////////////////////////////////////////////////////////////
	// lane register fields
	localparam int unsigned F_CTC           = 11;
	localparam int unsigned F_MF_HI         = 10;
	localparam int unsigned F_MF_LO         = 9;
	localparam int unsigned F_LOS_EN        = 8;
	localparam int unsigned F_CFG_UP        = 7;
	localparam int unsigned F_CFG_LO        = 6;
	localparam int unsigned F_EMPH_HI       = 5;
	localparam int unsigned F_EMPH_LO       = 4;
	localparam int unsigned F_LOOP          = 3;
	localparam int unsigned F_PAT           = 2;
	localparam int unsigned F_COMMA         = 1;
	localparam int unsigned F_PD            = 0;
	localparam logic [15:0] LANE_RESET      = 16'h0102;
	localparam logic [15:0] LANE_WR_MASK    = 16'h0fff;

	////////////////////////////////////////////////////////////////////////////////
	// bits of the base control word and of the lane status word
	localparam int unsigned BASE_LOOP       = 14;
	localparam int unsigned BASE_PD         = 11;
	localparam int unsigned STAT_LOSS_B     = 1;
	localparam int unsigned STAT_PASS_B     = 5;
	localparam int unsigned STAT_LOSS_C     = 2;
	localparam int unsigned STAT_PASS_C     = 6;

	////////////////////////////////////////////////////////////////////////////////
	// multifunction select codes
	localparam logic [1:0]  MF_IO_STD       = 2'h0;
	localparam logic [1:0]  MF_COMMA        = 2'h1;
	localparam logic [1:0]  MF_LOSS         = 2'h2;
	localparam logic [1:0]  MF_PASS         = 2'h3;

	////////////////////////////////////////////////////////////////////////////////
	// synchronised pin vector positions
	localparam int unsigned PIN_CFG_UP      = 0;
	localparam int unsigned PIN_CFG_LO      = 1;
	localparam int unsigned PIN_PAT         = 2;
	localparam int unsigned PIN_ALIGN       = 3;
	localparam int unsigned PIN_HSTL        = 4;
	localparam int unsigned PIN_W           = 5;

	////////////////////////////////////////////////////////////////////////////////
	// effective controls of one lane
	typedef struct packed {
		logic       ctc_en;
		logic [1:0] mf_sel;
		logic       loss_en;
		logic [1:0] cfg;
		logic [1:0] emph;
		logic       loop_en;
		logic       pat_en;
		logic       comma_en;
		logic       pwr_down;
		logic       multi_pin;
	} lcrp_eff_s;

	// whole state of the top module
	typedef struct packed {
		logic [15:0]      lane_b;
		logic [15:0]      lane_c;
		logic [PIN_W-1:0] pin_meta;
		logic [PIN_W-1:0] pin_sync;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} lcrp_state_s;

endpackage : lcrp_pkg

//--- hdl/lcrp_top.sv
// lcrp_top: lane b and lane c configuration registers behind an apb slave.
// assumes the global word, base control word, status word and comma flags come from
// logic on CLK_SYS_I; the four configuration pins and the io standard pin are async.
//
// Function
// - bits 15:12 read zero, writes dropped
// - compensation enable ORed with global bit 11
// - select picks io standard, comma, loss, pass
// - lane b uses status bits 1 and 5
// - lane c uses status bits 2 and 6
// - select ORed with global bits 10:9
// - loss detect ANDed with global bit 8
// - config bits writable only while pin low
// - config bits ORed with global bits 7:6
// - emphasis bits ORed with global bits 5:4
// - loopback ORed with base bit 14
// - pattern test ORed with global bit 2
// - pattern bit writable only while pin low
// - comma detect ANDs bit, align pin, global
// - power-down ORed with base bit 11
`timescale 1ns/100ps
module lcrp_top (
	input  wire logic                          CLK_SYS_I,           // 250 MHz clock
	input  wire logic                          RST_I,               // async reset, high
	input  wire logic                          PSEL_I,              // apb select
	input  wire logic                          PENABLE_I,           // apb access phase
	input  wire logic                          PWRITE_I,            // apb write
	input  wire logic [lcrp_pkg::ADDR_W-1:0]   PADDR_I,             // apb byte address
	input  wire logic [31:0]                   PWDATA_I,            // apb write data
	input  wire logic [3:0]                    PSTRB_I,             // apb byte strobes
	output logic                               PREADY_O,            // apb ready
	output logic                               PSLVERR_O,           // apb error
	output logic [31:0]                        PRDATA_O,            // apb read data
	input  wire logic [15:0]                   GLOBAL_CFG_I,        // global config word
	input  wire logic [15:0]                   BASE_CTRL_I,         // base control word
	input  wire logic [15:0]                   LANE_STATUS_I,       // lane status word
	input  wire logic [1:0]                    COMMA_SEEN_I,        // comma seen, [0]=b [1]=c
	input  wire logic                          CFG_PIN_UPPER_I,     // config pin, upper
	input  wire logic                          CFG_PIN_LOWER_I,     // config pin, lower
	input  wire logic                          PATTERN_TEST_PIN_I,  // pattern test pin
	input  wire logic                          ALIGN_ENABLE_PIN_I,  // align enable pin
	input  wire logic                          IO_STD_HSTL_I,       // io standard, 1 = hstl
	output lcrp_pkg::lcrp_eff_s                LANE_B_EFF_O,        // lane b controls
	output lcrp_pkg::lcrp_eff_s                LANE_C_EFF_O,        // lane c controls
	output logic                               LANE_B_MULTI_PIN_O,  // lane b multifunction
	output logic                               LANE_C_MULTI_PIN_O   // lane c multifunction
);

	lcrp_pkg::lcrp_state_s st_q;
	lcrp_pkg::lcrp_state_s st_d;
	lcrp_pkg::lcrp_eff_s   eff_b;
	lcrp_pkg::lcrp_eff_s   eff_c;
	logic                  hit_b;
	logic                  hit_c;
	logic                  access;
	logic                  commit;

	////////////////////////////////////////////////////////////////////////////////
	// write merge: strobes pick the bytes, reserved bits are dropped, pin-held bits keep
	function automatic logic [15:0] lane_write(
		input logic [15:0]                old_v,
		input logic [15:0]                wdata,
		input logic [1:0]                 strb,
		input logic [lcrp_pkg::PIN_W-1:0] pins
	);
		logic [15:0] nv;
		nv = old_v;
		if (strb[0]) begin
			nv[7:0] = wdata[7:0];
		end
		if (strb[1]) begin
			nv[15:8] = wdata[15:8];
		end
		nv = nv & lcrp_pkg::LANE_WR_MASK;
		if (pins[lcrp_pkg::PIN_CFG_UP]) begin
			nv[lcrp_pkg::F_CFG_UP] = old_v[lcrp_pkg::F_CFG_UP];
		end
		if (pins[lcrp_pkg::PIN_CFG_LO]) begin
			nv[lcrp_pkg::F_CFG_LO] = old_v[lcrp_pkg::F_CFG_LO];
		end
		if (pins[lcrp_pkg::PIN_PAT]) begin
			nv[lcrp_pkg::F_PAT] = old_v[lcrp_pkg::F_PAT];
		end
		return nv;
	endfunction : lane_write

	////////////////////////////////////////////////////////////////////////////////
	// decode: only the two aligned words answer, everything else is an error
	assign hit_b  = (PADDR_I == lcrp_pkg::LANE_B_ADDR);
	assign hit_c  = (PADDR_I == lcrp_pkg::LANE_C_ADDR);
	assign access = PSEL_I & PENABLE_I;
	// one wait state: ready rises the cycle after the access phase opens
	assign commit = access & st_q.pready;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d          = st_q;
		// two-flop synchroniser; only the second stage feeds any logic
		st_d.pin_meta = {IO_STD_HSTL_I, ALIGN_ENABLE_PIN_I, PATTERN_TEST_PIN_I,
			CFG_PIN_LOWER_I, CFG_PIN_UPPER_I};
		st_d.pin_sync = st_q.pin_meta;

		if (commit) begin
			st_d.pready  = 1'b0;
			st_d.pslverr = 1'b0;
			st_d.prdata  = 32'h0000_0000;
			if (PWRITE_I && hit_b) begin
				st_d.lane_b = lane_write(st_q.lane_b, PWDATA_I[15:0], PSTRB_I[1:0],
					st_q.pin_sync);
			end
			if (PWRITE_I && hit_c) begin
				st_d.lane_c = lane_write(st_q.lane_c, PWDATA_I[15:0], PSTRB_I[1:0],
					st_q.pin_sync);
			end
		end else if (access) begin
			st_d.pready  = 1'b1;
			st_d.pslverr = ~(hit_b | hit_c);
			st_d.prdata  = 32'h0000_0000;
			if (!PWRITE_I && hit_b) begin
				st_d.prdata = {16'h0000, st_q.lane_b & lcrp_pkg::LANE_WR_MASK};
			end
			if (!PWRITE_I && hit_c) begin
				st_d.prdata = {16'h0000, st_q.lane_c & lcrp_pkg::LANE_WR_MASK};
			end
		end else begin
			st_d.pready  = 1'b0;
			st_d.pslverr = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			st_q        <= '0;
			st_q.lane_b <= lcrp_pkg::LANE_RESET;
			st_q.lane_c <= lcrp_pkg::LANE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-lane effective controls
	lcrp_lane #(
		.LOSS_BIT (lcrp_pkg::STAT_LOSS_B),
		.PASS_BIT (lcrp_pkg::STAT_PASS_B)
	) u_lane_b (
		.clk_i      (CLK_SYS_I),
		.rst_i      (RST_I),
		.lane_reg_i (st_q.lane_b),
		.global_i   (GLOBAL_CFG_I),
		.base_i     (BASE_CTRL_I),
		.status_i   (LANE_STATUS_I),
		.comma_i    (COMMA_SEEN_I[0]),
		.hstl_i     (st_q.pin_sync[lcrp_pkg::PIN_HSTL]),
		.align_i    (st_q.pin_sync[lcrp_pkg::PIN_ALIGN]),
		.eff_o      (eff_b)
	);

	lcrp_lane #(
		.LOSS_BIT (lcrp_pkg::STAT_LOSS_C),
		.PASS_BIT (lcrp_pkg::STAT_PASS_C)
	) u_lane_c (
		.clk_i      (CLK_SYS_I),
		.rst_i      (RST_I),
		.lane_reg_i (st_q.lane_c),
		.global_i   (GLOBAL_CFG_I),
		.base_i     (BASE_CTRL_I),
		.status_i   (LANE_STATUS_I),
		.comma_i    (COMMA_SEEN_I[1]),
		.hstl_i     (st_q.pin_sync[lcrp_pkg::PIN_HSTL]),
		.align_i    (st_q.pin_sync[lcrp_pkg::PIN_ALIGN]),
		.eff_o      (eff_c)
	);

	////////////////////////////////////////////////////////////////////////////////
	assign PREADY_O           = st_q.pready;
	assign PSLVERR_O          = st_q.pslverr;
	assign PRDATA_O           = st_q.prdata;
	assign LANE_B_EFF_O       = eff_b;
	assign LANE_C_EFF_O       = eff_c;
	assign LANE_B_MULTI_PIN_O = eff_b.multi_pin;
	assign LANE_C_MULTI_PIN_O = eff_c.multi_pin;

endmodule : lcrp_top

//--- verification/lcrp_top_properties.sv
// checker: apb timing and effective-control relations of lcrp_top.
// assumes it is bound into lcrp_top and sees only that module's ports.
`timescale 1ns/100ps
module lcrp_top_properties (
	input wire logic                         CLK_SYS_I,          // clock
	input wire logic                         RST_I,              // reset
	input wire logic                         PSEL_I,             // select
	input wire logic                         PENABLE_I,          // access phase
	input wire logic [lcrp_pkg::ADDR_W-1:0]  PADDR_I,            // address
	input wire logic                         PREADY_O,           // ready
	input wire logic                         PSLVERR_O,          // error
	input wire logic [31:0]                  PRDATA_O,           // read data
	input wire logic [15:0]                  GLOBAL_CFG_I,       // global word
	input wire logic [15:0]                  BASE_CTRL_I,        // base word
	input wire logic [15:0]                  LANE_STATUS_I,      // status word
	input lcrp_pkg::lcrp_eff_s               LANE_B_EFF_O,       // lane b controls
	input lcrp_pkg::lcrp_eff_s               LANE_C_EFF_O,       // lane c controls
	input wire logic                         LANE_B_MULTI_PIN_O, // lane b pin
	input wire logic                         LANE_C_MULTI_PIN_O  // lane c pin
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	wire logic access_w = PSEL_I && PENABLE_I && !PREADY_O;
	wire logic mapped_w = PADDR_I == lcrp_pkg::LANE_B_ADDR || PADDR_I == lcrp_pkg::LANE_C_ADDR;

	////////////////////////////////////////////////////////////////////////////////
	// pass select held with a steady status word, long enough to reach the pins
	sequence s_pass_held;
		(GLOBAL_CFG_I[10:9] == 2'h3 && $stable(LANE_STATUS_I)) [*2];
	endsequence

	a_ready_wait: assert property (access_w |=> PREADY_O) else $error("ready late");
	a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready held");
	a_reserved_zero: assert property (PREADY_O |-> PRDATA_O[31:12] == 20'h0)
		else $error("reserved read bits set");
	a_unmapped_err: assert property (access_w && !mapped_w |=> PSLVERR_O && PRDATA_O == 32'h0)
		else $error("unmapped access not refused");
	a_ctc_or: assert property (GLOBAL_CFG_I[11] |=> LANE_B_EFF_O.ctc_en && LANE_C_EFF_O.ctc_en)
		else $error("compensation not forced");
	a_sel_or: assert property (1'b1 |=> (LANE_B_EFF_O.mf_sel & $past(GLOBAL_CFG_I[10:9]))
		== $past(GLOBAL_CFG_I[10:9])) else $error("select not ored");
	a_loss_and: assert property (!GLOBAL_CFG_I[8] |=> !LANE_B_EFF_O.loss_en && !LANE_C_EFF_O.loss_en)
		else $error("loss detect not gated");
	a_loop_or: assert property (BASE_CTRL_I[14] |=> LANE_B_EFF_O.loop_en && LANE_C_EFF_O.loop_en)
		else $error("loopback not forced");
	a_pd_or: assert property (BASE_CTRL_I[11] |=> LANE_B_EFF_O.pwr_down && LANE_C_EFF_O.pwr_down)
		else $error("power-down not forced");
	a_pass_pin: assert property (s_pass_held |=> LANE_B_MULTI_PIN_O == $past(LANE_STATUS_I[5])
		&& LANE_C_MULTI_PIN_O == $past(LANE_STATUS_I[6])) else $error("pass status not on pin");
endmodule : lcrp_top_properties

bind lcrp_top lcrp_top_properties u_props (.CLK_SYS_I, .RST_I, .PSEL_I, .PENABLE_I, .PADDR_I,
	.PREADY_O, .PSLVERR_O, .PRDATA_O, .GLOBAL_CFG_I, .BASE_CTRL_I, .LANE_STATUS_I,
	.LANE_B_EFF_O, .LANE_C_EFF_O, .LANE_B_MULTI_PIN_O, .LANE_C_MULTI_PIN_O);

//--- verification/lcrp_top_tb_top.sv
// lcrp_top_tb_top: apb register checks and effective-control checks of both lanes.
// assumes lcrp_pkg and lcrp_top are compiled first; the bench drives every input.
`timescale 1ns/100ps
module lcrp_top_tb_top;
	logic                clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [9:0]          paddr = 10'h0;
	logic [31:0]         pwdata = 32'h0, prdata;
	logic [3:0]          pstrb = 4'hf;
	logic                pready, pslverr, pin_b, pin_c, hstl = 1'b0, align = 1'b0;
	logic                cfg_up = 1'b0, cfg_lo = 1'b0, pat = 1'b0;
	logic [15:0]         glob = 16'h0, base = 16'h0, stat = 16'h0;
	logic [1:0]          comma = 2'h0;
	lcrp_pkg::lcrp_eff_s eff_b, eff_c, eb, ec;
	int                  n_errors = 0, num_checks = 0, cycles = 0;
	// per step: lane b value, lane c value, global, base, status
	logic [15:0] tv [0:5][0:4] = '{'{16'h0000, 16'h0fff, 16'h0000, 16'h0000, 16'h0000},
		'{16'h0202, 16'h0400, 16'h0102, 16'h4000, 16'h0004},
		'{16'h0400, 16'h0600, 16'h0102, 16'h0800, 16'h0064},
		'{16'h0102, 16'h0000, 16'h0602, 16'h0000, 16'h0022},
		'{16'h0b5a, 16'h04a5, 16'h0dff, 16'h4800, 16'h0006},
		'{16'h0000, 16'h0000, 16'h0200, 16'h0000, 16'h0000}};

	always #2 clk = ~clk;

	lcrp_top u_dut (.CLK_SYS_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.PRDATA_O(prdata), .GLOBAL_CFG_I(glob), .BASE_CTRL_I(base), .LANE_STATUS_I(stat),
		.COMMA_SEEN_I(comma), .CFG_PIN_UPPER_I(cfg_up), .CFG_PIN_LOWER_I(cfg_lo),
		.PATTERN_TEST_PIN_I(pat), .ALIGN_ENABLE_PIN_I(align), .IO_STD_HSTL_I(hstl),
		.LANE_B_EFF_O(eff_b), .LANE_C_EFF_O(eff_c), .LANE_B_MULTI_PIN_O(pin_b),
		.LANE_C_MULTI_PIN_O(pin_c));

	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		if (n_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// one transfer; an idle cycle always separates two calls
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		// request stands until the rising edge at which ready is seen high
		do @(posedge clk); while (pready !== 1'b1);
		check({31'h0, pslverr}, {31'h0, a != lcrp_pkg::LANE_B_ADDR && a != lcrp_pkg::LANE_C_ADDR});
		if (!wr) check(prdata, wd);
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb

	function automatic lcrp_pkg::lcrp_eff_s exp_eff(input logic [15:0] r, input logic signal_loss,
		input logic pas, input logic cs);
		lcrp_pkg::lcrp_eff_s e;
		e.ctc_en    = r[11] | glob[11];
		e.mf_sel    = r[10:9] | glob[10:9];
		e.loss_en   = r[8] & glob[8];
		e.cfg       = r[7:6] | glob[7:6];
		e.emph      = r[5:4] | glob[5:4];
		e.loop_en   = r[3] | base[14];
		e.pat_en    = r[2] | glob[2];
		e.comma_en  = r[1] & align & glob[1];
		e.pwr_down  = r[0] | base[11];
		e.multi_pin = e.mf_sel[1] ? (e.mf_sel[0] ? pas : signal_loss) : (e.mf_sel[0] ? cs : hstl);
		return e;
	endfunction : exp_eff

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			results();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, lcrp_pkg::LANE_B_ADDR, 32'h0000_0102);
		apb(1'b0, lcrp_pkg::LANE_C_ADDR, 32'h0000_0102);
		apb(1'b1, lcrp_pkg::LANE_B_ADDR, 32'hffff_ffff);
		apb(1'b0, lcrp_pkg::LANE_B_ADDR, 32'h0000_0fff);
		apb(1'b1, 10'h050, 32'h0000_0abc);
		apb(1'b0, 10'h050, 32'h0000_0000);
		apb(1'b0, lcrp_pkg::LANE_B_ADDR, 32'h0000_0fff);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, lcrp_pkg::LANE_B_ADDR, {16'h0, tv[i][0]});
			apb(1'b1, lcrp_pkg::LANE_C_ADDR, {16'h0, tv[i][1]});
			glob  <= tv[i][2];
			base  <= tv[i][3];
			stat  <= tv[i][4];
			comma <= i[1:0];
			align <= i[0];
			hstl  <= ~i[1];
			// sync pins need two edges, the outputs one more
			repeat (5) @(posedge clk);
			@(negedge clk);
			eb = exp_eff(tv[i][0], stat[1], stat[5], comma[0]);
			ec = exp_eff(tv[i][1], stat[2], stat[6], comma[1]);
			check({18'h0, pin_b, eff_b}, {18'h0, eb.multi_pin, eb});
			check({18'h0, pin_c, eff_c}, {18'h0, ec.multi_pin, ec});
		end
		apb(1'b1, lcrp_pkg::LANE_B_ADDR, 32'h0000_00c4);
		apb(1'b1, lcrp_pkg::LANE_C_ADDR, 32'h0000_0000);
		cfg_up <= 1'b1;
		cfg_lo <= 1'b1;
		pat    <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b1, lcrp_pkg::LANE_B_ADDR, 32'h0000_0000);
		apb(1'b1, lcrp_pkg::LANE_C_ADDR, 32'h0000_0fff);
		apb(1'b0, lcrp_pkg::LANE_B_ADDR, 32'h0000_00c4);
		apb(1'b0, lcrp_pkg::LANE_C_ADDR, 32'h0000_0f3b);
		cfg_up <= 1'b0;
		cfg_lo <= 1'b0;
		pat    <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b1, lcrp_pkg::LANE_C_ADDR, 32'h0000_0fff);
		apb(1'b0, lcrp_pkg::LANE_C_ADDR, 32'h0000_0fff);
		// byte strobes: low byte alone, then high byte alone with reserved bits set
		pstrb <= 4'h1;
		apb(1'b1, lcrp_pkg::LANE_C_ADDR, 32'h0000_0000);
		pstrb <= 4'h2;
		apb(1'b0, lcrp_pkg::LANE_C_ADDR, 32'h0000_0f00);
		apb(1'b1, lcrp_pkg::LANE_C_ADDR, 32'hffff_f0ff);
		apb(1'b0, lcrp_pkg::LANE_C_ADDR, 32'h0000_0000);
		pstrb <= 4'hf;
		results();
	end
endmodule : lcrp_top_tb_top
